/* hdl/asf_pkg.sv */
// Constants, register map and carrier types of the asynchronous serial port.
// Assumes a 100 MHz module clock and a 32-bit AXI4-Lite register bus.
//
// Overview of operation
// - Break length 10/11 or 13/14 bits.
// - Framing error detection ignores break-length select.
// - Single-wire pin direction from pin-direction bit.
// - First-slot start sample sets receiver active, unless a framing error is pending.
// - Idle character clears receiver active.
// - Status two: only bits 1,2 writable.
// - Data read gives receive, write loads transmit.
// - Ninth received bit in high bit 7.
// - Ninth transmit bit kept and resent.
// - Frame is start, 8/9 data, stop.
// - Transmitter and receiver independent, shared baud.
// - Thirteen-bit divisor split across baud registers.
// - Receiver sixteen samples; transmitter divides by sixteen.
// - Bit rate is clock over sixteen times divisor.
// - Divisor zero stops; high waits for low.
// - Parity replaces data msb, odd or even.
// - Breaks repeat while set, then one mark.
package asf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_BAUD_HIGH = 4'h0;
	localparam logic [3:0] IDX_BAUD_LOW = 4'h1;
	localparam logic [3:0] IDX_CTRL_ONE = 4'h2;
	localparam logic [3:0] IDX_CTRL_TWO = 4'h3;
	localparam logic [3:0] IDX_STATUS_ONE = 4'h4;
	localparam logic [3:0] IDX_STATUS_TWO = 4'h5;
	localparam logic [3:0] IDX_DATA_HIGH = 4'h6;
	localparam logic [3:0] IDX_DATA_LOW = 4'h7;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h8;
	// Field positions
	localparam int CTL1_PARITY_ODD = 0;
	localparam int CTL1_PARITY_EN = 1;
	localparam int CTL1_CHAR9 = 4;
	localparam int CTL1_SINGLE_WIRE = 5;
	localparam int CTL2_SEND_BREAK = 0;
	localparam int CTL2_RX_EN = 2;
	localparam int CTL2_TX_EN = 3;
	localparam int ST2_RAF = 0;
	localparam int ST2_PIN_DIR = 1;
	localparam int ST2_LONG_BRK = 2;
	localparam int DH_RX_NINTH = 7;
	localparam int DH_TX_NINTH = 6;
	localparam int ST1_TDRE = 6;
	// Event bits of status one and of the mask register
	localparam int EV_RX_FULL = 0;
	localparam int EV_TX_EMPTY = 1;
	localparam int EV_OVERRUN = 2;
	localparam int EV_FRAME_ERR = 3;
	localparam int EV_PARITY_ERR = 4;
	localparam int EV_IDLE = 5;
	localparam int NUM_EV = 6;
	// Frame and sampling constants
	localparam logic [3:0] FRAME_SHORT = 4'ha;
	localparam logic [3:0] FRAME_LONG = 4'hb;
	localparam logic [3:0] BREAK_SHORT = 4'hd;
	localparam logic [3:0] BREAK_LONG = 4'he;
	localparam logic [3:0] SLOT_LAST = 4'hf;
	localparam logic [3:0] SLOT_MID = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {TX_IDLE, TX_SHIFT} asf_tx_st_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} asf_rx_st_t;

	// Software configuration
	typedef struct packed {
		logic [4:0] baud_hi_pend;
		logic [12:0] divisor;
		logic char9;
		logic parity_en;
		logic parity_odd;
		logic single_wire;
		logic tx_en;
		logic rx_en;
		logic send_break;
		logic long_break_select;
		logic single_wire_pin_dir;
		logic [NUM_EV-1:0] irq_mask;
	} asf_cfg_t;

	// AXI4-Lite slave side state
	typedef struct packed {
		logic aw_have;
		logic w_have;
		logic [3:0] widx;
		logic [7:0] wdata;
		logic wlane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asf_bus_t;

	// Byte address of a register index
	function automatic logic [7:0] asf_addr(input logic [3:0] idx);
		asf_addr = {2'h0, idx, 2'h0};
	endfunction : asf_addr
endpackage : asf_pkg

/* hdl/asf_serial_port.sv */
// Asynchronous serial port: AXI4-Lite registers, baud divider, transmitter and receiver.
// Assumes txd_i and rxd_i are asynchronous pins; the pad merges txd_o and txd_oe_n.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module asf_serial_port
	import asf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins
	input wire logic rxd_i,
	input wire logic txd_i,
	output logic txd_o,
	output logic txd_oe_n,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		asf_bus_t bus;
		asf_cfg_t cfg;
		logic tx_ninth_bit;
		logic [7:0] tx_buf;
		logic tdr_full;
		logic [7:0] rx_data;
		logic rx_ninth_bit;
		logic [NUM_EV-1:0] ev;
		logic irq;
		logic [12:0] baud_cnt;
		logic rt_tick;
		logic te_prev;
		logic preamble_due;
		logic brk_tail;
		logic tx_is_break;
		asf_tx_st_t tx_st;
		logic [13:0] tx_sh;
		logic [3:0] tx_left;
		logic [3:0] tx_sub;
		logic txd;
		logic txd_oe_n;
		logic [1:0] rxd_sync;
		logic [1:0] txd_sync;
		asf_rx_st_t rx_st;
		logic [3:0] rx_sub;
		logic [3:0] rx_bit;
		logic [8:0] rx_sh;
		logic [7:0] idle_cnt;
		logic receiver_active_flag;
	} asf_state_t;

	asf_state_t s_q;
	asf_state_t s_d;

	// Frame length in bits for the current character size
	function automatic logic [3:0] frame_len(input logic char9);
		frame_len = char9 ? FRAME_LONG : FRAME_SHORT;
	endfunction : frame_len

	// Flag for a mapped byte address: word aligned, index no higher than the mask register
	function automatic logic map_ok(input logic [7:0] a);
		map_ok = (a[1:0] == 2'h0) && (a[7:2] <= {2'h0, IDX_IRQ_MASK});
	endfunction : map_ok

	logic rx_in;
	logic [8:0] tx_char;
	logic [3:0] ridx;
	logic [7:0] rbyte;
	logic bit_end;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] ev_clr;
	logic load_now;
	logic wr_fire;
	logic [3:0] nbits;
	logic [7:0] idle_lim;

	always_comb begin
		s_d = s_q;
		ev_set = '0;
		ev_clr = '0;
		wr_fire = 1'b0;
		load_now = 1'b0;
		bit_end = 1'b0;
		tx_char = '0;
		ridx = '0;
		rbyte = '0;
		nbits = s_q.cfg.char9 ? 4'h9 : 4'h8;
		idle_lim = {s_q.cfg.char9 ? FRAME_LONG : FRAME_SHORT, 4'h0};

		// Two-flop synchronisers on both pins
		s_d.rxd_sync = {s_q.rxd_sync[0], rxd_i};
		s_d.txd_sync = {s_q.txd_sync[0], txd_i};
		// Single-wire mode listens on the transmit pin
		rx_in = s_q.cfg.single_wire ? s_q.txd_sync[1] : s_q.rxd_sync[1];

		// Write path: address and data accepted in either order
		if (s_axi_awvalid && s_q.bus.awready) begin
			s_d.bus.aw_have = 1'b1;
			s_d.bus.widx = map_ok(s_axi_awaddr) ? s_axi_awaddr[5:2] : 4'hf;
		end
		if (s_axi_wvalid && s_q.bus.wready) begin
			s_d.bus.w_have = 1'b1;
			s_d.bus.wdata = s_axi_wdata[7:0];
			s_d.bus.wlane0 = s_axi_wstrb[0];
		end
		if (s_q.bus.bvalid && s_axi_bready) begin
			s_d.bus.bvalid = 1'b0;
		end
		if (s_q.bus.aw_have && s_q.bus.w_have && !s_q.bus.bvalid) begin
			wr_fire = s_q.bus.wlane0;
			s_d.bus.aw_have = 1'b0;
			s_d.bus.w_have = 1'b0;
			s_d.bus.bvalid = 1'b1;
			s_d.bus.bresp = (s_q.bus.widx == 4'hf) ? RESP_SLVERR : RESP_OKAY;
		end
		s_d.bus.awready = !s_d.bus.aw_have && !s_d.bus.bvalid;
		s_d.bus.wready = !s_d.bus.w_have && !s_d.bus.bvalid;

		// Register writes; only byte lane 0 carries data
		if (wr_fire) begin
			case (s_q.bus.widx)
				IDX_BAUD_HIGH: s_d.cfg.baud_hi_pend = s_q.bus.wdata[4:0]; // Held until low written
				IDX_BAUD_LOW: s_d.cfg.divisor = {s_q.cfg.baud_hi_pend, s_q.bus.wdata};
				IDX_CTRL_ONE: begin
					s_d.cfg.parity_odd = s_q.bus.wdata[CTL1_PARITY_ODD];
					s_d.cfg.parity_en = s_q.bus.wdata[CTL1_PARITY_EN];
					s_d.cfg.char9 = s_q.bus.wdata[CTL1_CHAR9];
					s_d.cfg.single_wire = s_q.bus.wdata[CTL1_SINGLE_WIRE];
				end
				IDX_CTRL_TWO: begin
					s_d.cfg.send_break = s_q.bus.wdata[CTL2_SEND_BREAK];
					s_d.cfg.rx_en = s_q.bus.wdata[CTL2_RX_EN];
					s_d.cfg.tx_en = s_q.bus.wdata[CTL2_TX_EN];
				end
				IDX_STATUS_ONE: ev_clr = s_q.bus.wdata[NUM_EV-1:0];
				IDX_STATUS_TWO: begin
					s_d.cfg.single_wire_pin_dir = s_q.bus.wdata[ST2_PIN_DIR]; // Other bits ignored
					s_d.cfg.long_break_select = s_q.bus.wdata[ST2_LONG_BRK];
				end
				IDX_DATA_HIGH: s_d.tx_ninth_bit = s_q.bus.wdata[DH_TX_NINTH]; // Bit 7 ignored
				IDX_DATA_LOW: begin
					s_d.tx_buf = s_q.bus.wdata; // Character complete on low write
					s_d.tdr_full = 1'b1;
				end
				IDX_IRQ_MASK: s_d.cfg.irq_mask = s_q.bus.wdata[NUM_EV-1:0];
				default: ;
			endcase
		end

		// Read path: one read under way, answer one cycle after acceptance
		if (s_q.bus.rvalid && s_axi_rready) begin
			s_d.bus.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.bus.arready) begin
			ridx = map_ok(s_axi_araddr) ? s_axi_araddr[5:2] : 4'hf; // Unmapped places read as zero
			case (ridx)
				IDX_BAUD_HIGH: rbyte = {3'h0, s_q.cfg.baud_hi_pend};
				IDX_BAUD_LOW: rbyte = s_q.cfg.divisor[7:0];
				IDX_CTRL_ONE: begin
					rbyte[CTL1_PARITY_ODD] = s_q.cfg.parity_odd;
					rbyte[CTL1_PARITY_EN] = s_q.cfg.parity_en;
					rbyte[CTL1_CHAR9] = s_q.cfg.char9;
					rbyte[CTL1_SINGLE_WIRE] = s_q.cfg.single_wire;
				end
				IDX_CTRL_TWO: begin
					rbyte[CTL2_SEND_BREAK] = s_q.cfg.send_break;
					rbyte[CTL2_RX_EN] = s_q.cfg.rx_en;
					rbyte[CTL2_TX_EN] = s_q.cfg.tx_en;
				end
				IDX_STATUS_ONE: begin
					rbyte[NUM_EV-1:0] = s_q.ev;
					rbyte[ST1_TDRE] = !s_q.tdr_full;
				end
				IDX_STATUS_TWO: begin // Readable at any time
					rbyte[ST2_RAF] = s_q.receiver_active_flag;
					rbyte[ST2_PIN_DIR] = s_q.cfg.single_wire_pin_dir;
					rbyte[ST2_LONG_BRK] = s_q.cfg.long_break_select;
				end
				IDX_DATA_HIGH: rbyte[DH_RX_NINTH] = s_q.rx_ninth_bit;
				IDX_DATA_LOW: rbyte = s_q.rx_data; // Receive buffer
				IDX_IRQ_MASK: rbyte[NUM_EV-1:0] = s_q.cfg.irq_mask;
				default: rbyte = '0;
			endcase
			s_d.bus.rvalid = 1'b1;
			s_d.bus.rdata = {24'h0, rbyte};
			s_d.bus.rresp = map_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.bus.arready = !s_d.bus.rvalid;

		// Baud divider: 16x sample tick, stopped while divisor is zero
		s_d.rt_tick = 1'b0;
		if (s_q.cfg.divisor == '0) begin
			s_d.baud_cnt = '0;
		end else if (s_q.baud_cnt >= s_q.cfg.divisor - 13'h1) begin
			s_d.baud_cnt = '0;
			s_d.rt_tick = 1'b1; // One tick per divisor clocks
		end else begin
			s_d.baud_cnt = s_q.baud_cnt + 13'h1;
		end

		// Transmitter: one bit every 16 ticks, shared divider
		s_d.te_prev = s_q.cfg.tx_en;
		if (s_q.cfg.tx_en && !s_q.te_prev) begin
			s_d.preamble_due = 1'b1;
		end
		if (s_q.tx_st == TX_SHIFT && s_q.rt_tick) begin
			s_d.tx_sub = s_q.tx_sub + 4'h1;
			if (s_q.tx_sub == SLOT_LAST) begin
				bit_end = 1'b1;
				s_d.tx_sh = {1'b1, s_q.tx_sh[13:1]};
				s_d.tx_left = s_q.tx_left - 4'h1;
				s_d.txd = s_q.tx_sh[1];
			end
		end
		// A new character loads on a tick when idle, or after the last bit;
		// waiting for the tick keeps the first bit a full sixteen ticks long
		load_now = (s_q.tx_st == TX_IDLE && s_q.rt_tick) || (bit_end && s_q.tx_left == 4'h1);
		if (load_now) begin
			s_d.tx_st = TX_IDLE;
			s_d.txd = 1'b1;
			s_d.tx_sub = '0;
			s_d.tx_is_break = 1'b0;
			if (s_q.cfg.tx_en && s_q.cfg.divisor != '0) begin
				s_d.tx_st = TX_SHIFT;
				if (s_d.preamble_due) begin
					s_d.preamble_due = 1'b0;
					s_d.tx_sh = '1;
					s_d.tx_left = frame_len(s_q.cfg.char9);
				end else if (s_q.cfg.send_break) begin
					s_d.tx_sh = '0; // No start, stop or parity
					s_d.tx_is_break = 1'b1;
					s_d.brk_tail = 1'b1;
					if (s_q.cfg.long_break_select) begin
						s_d.tx_left = s_q.cfg.char9 ? BREAK_LONG : BREAK_SHORT;
					end else begin
						s_d.tx_left = frame_len(s_q.cfg.char9);
					end
				end else if (s_q.brk_tail) begin
					s_d.brk_tail = 1'b0;
					s_d.tx_sh = '1; // One mark after break ends
					s_d.tx_left = 4'h1;
				end else if (s_q.tdr_full) begin
					tx_char = {s_q.tx_ninth_bit, s_q.tx_buf}; // Ninth bit reused
					if (s_q.cfg.parity_en && s_q.cfg.char9) begin
						tx_char[8] = (^s_q.tx_buf) ^ s_q.cfg.parity_odd;
					end else if (s_q.cfg.parity_en) begin
						tx_char[7] = (^s_q.tx_buf[6:0]) ^ s_q.cfg.parity_odd;
					end
					if (s_q.cfg.char9) begin
						s_d.tx_sh = {4'hf, tx_char, 1'b0};
					end else begin
						s_d.tx_sh = {5'h1f, tx_char[7:0], 1'b0};
					end
					s_d.tx_left = frame_len(s_q.cfg.char9);
					s_d.tdr_full = 1'b0;
					ev_set[EV_TX_EMPTY] = 1'b1;
				end else begin
					s_d.tx_st = TX_IDLE;
				end
				if (s_d.tx_st == TX_SHIFT) begin
					s_d.txd = s_d.tx_sh[0];
				end
			end
		end
		// Low write in the same cycle as a transfer keeps the new character
		if (wr_fire && s_q.bus.widx == IDX_DATA_LOW) begin
			s_d.tdr_full = 1'b1;
		end
		// Pin direction only matters in single-wire mode
		s_d.txd_oe_n = s_q.cfg.single_wire && !s_q.cfg.single_wire_pin_dir;

		// Receiver: 16 samples per bit, independent of transmitter
		if (s_q.rt_tick) begin
			case (s_q.rx_st)
				RX_IDLE: begin
					if (rx_in == 1'b0 && s_q.cfg.rx_en && !s_q.ev[EV_FRAME_ERR]) begin
						s_d.receiver_active_flag = 1'b1; // Zero in first slot
						s_d.rx_st = RX_START;
						s_d.rx_sub = 4'h1;
						s_d.idle_cnt = '0;
					end else if (rx_in == 1'b1) begin
						if (s_q.idle_cnt < idle_lim) begin
							s_d.idle_cnt = s_q.idle_cnt + 8'h1;
						end
						if (s_q.idle_cnt == idle_lim - 8'h1) begin
							s_d.receiver_active_flag = 1'b0; // Idle character seen
							ev_set[EV_IDLE] = s_q.receiver_active_flag;
						end
					end else begin
						s_d.idle_cnt = '0;
					end
				end
				RX_START: begin
					s_d.rx_sub = s_q.rx_sub + 4'h1;
					if (s_q.rx_sub == SLOT_MID && rx_in) begin
						s_d.rx_st = RX_IDLE; // False start, line went back high
					end else if (s_q.rx_sub == SLOT_LAST) begin
						s_d.rx_st = RX_DATA;
						s_d.rx_bit = '0;
					end
				end
				RX_DATA: begin
					s_d.rx_sub = s_q.rx_sub + 4'h1;
					if (s_q.rx_sub == SLOT_MID) begin
						s_d.rx_sh[s_q.rx_bit] = rx_in;
					end
					if (s_q.rx_sub == SLOT_LAST) begin
						s_d.rx_bit = s_q.rx_bit + 4'h1;
						if (s_q.rx_bit == nbits - 4'h1) begin
							s_d.rx_st = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					s_d.rx_sub = s_q.rx_sub + 4'h1;
					if (s_q.rx_sub == SLOT_MID) begin
						s_d.rx_st = RX_IDLE;
						s_d.idle_cnt = '0;
						if (s_q.ev[EV_RX_FULL]) begin
							ev_set[EV_OVERRUN] = 1'b1; // Buffer kept
						end else begin
							s_d.rx_data = s_q.rx_sh[7:0];
							s_d.rx_ninth_bit = s_q.cfg.char9 && s_q.rx_sh[8];
							ev_set[EV_RX_FULL] = 1'b1;
							ev_set[EV_FRAME_ERR] = !rx_in; // Break length not involved
							if (s_q.cfg.char9) begin
								ev_set[EV_PARITY_ERR] = s_q.cfg.parity_en && ((^s_q.rx_sh) ^ s_q.cfg.parity_odd);
							end else begin
								ev_set[EV_PARITY_ERR] = s_q.cfg.parity_en && ((^s_q.rx_sh[7:0]) ^ s_q.cfg.parity_odd);
							end
						end
					end
				end
				default: s_d.rx_st = RX_IDLE;
			endcase
		end
		if (!s_q.cfg.rx_en) begin
			s_d.rx_st = RX_IDLE;
		end

		// Sticky events: a set in the clearing cycle wins
		s_d.ev = (s_q.ev & ~ev_clr) | ev_set;
		s_d.irq = |(s_d.ev & s_q.cfg.irq_mask);
	end

	// Single register stage for the whole state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.bus.awready <= 1'b1;
			s_q.bus.wready <= 1'b1;
			s_q.bus.arready <= 1'b1;
			s_q.txd <= 1'b1;
			s_q.rxd_sync <= 2'h3;
			s_q.txd_sync <= 2'h3;
			s_q.tx_st <= TX_IDLE;
			s_q.rx_st <= RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready = s_q.bus.awready;
	assign s_axi_wready = s_q.bus.wready;
	assign s_axi_bvalid = s_q.bus.bvalid;
	assign s_axi_bresp = s_q.bus.bresp;
	assign s_axi_arready = s_q.bus.arready;
	assign s_axi_rvalid = s_q.bus.rvalid;
	assign s_axi_rdata = s_q.bus.rdata;
	assign s_axi_rresp = s_q.bus.rresp;
	assign txd_o = s_q.txd;
	assign txd_oe_n = s_q.txd_oe_n;
	assign irq = s_q.irq;

endmodule : asf_serial_port
`default_nettype wire

/* verif/asf_chk.sv */
// Checker for the serial port top: bus handshakes and serial bit timing.
// Sees only top-level ports; attached by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module asf_chk import asf_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial line and interrupt
	input wire logic txd_o,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic prev_q;
	logic [4:0] run_q;
	// Clocks since the line last moved; saturates so long idles never wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_q <= 1'b1;
			run_q <= 5'h1f;
		end else begin
			prev_q <= txd_o;
			run_q <= (txd_o != prev_q) ? 5'h00 : ((run_q == 5'h1f) ? run_q : run_q + 5'h01);
		end
	end
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address taken while data pending");
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_w_block: assert property (p_w_block) else $error("write taken while response pending");
	property p_aw_once; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_once: assert property (p_aw_once) else $error("second address taken");
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");
	// Each serial bit lasts sixteen ticks, so at least sixteen clocks
	property p_bit_len; (txd_o != prev_q) |-> run_q >= 5'h0f; endproperty
	a_bit_len: assert property (p_bit_len) else $error("serial bit too short");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_start: cover property ($fell(txd_o));
	c_irq: cover property ($rose(irq));
endmodule : asf_chk
bind asf_serial_port asf_chk u_chk (.clk(clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd_o(txd_o), .irq(irq));
`default_nettype wire

/* verif/asf_remote.sv */
// Remote serial device: sends frames on the receive pin and decodes the line.
// Assumes a fixed bit time in clocks that matches the programmed divisor.
`timescale 1ns/1ps
`default_nettype none
module asf_remote #(parameter int BIT = 32) (
	// Clock
	input wire logic clk,
	// Serial line
	input wire logic txd,
	output logic rxd
);
	// Idle mark until a frame is sent
	initial rxd = 1'b1;
	// Start, data lsb first, stop; a zero stop forces a framing error
	task automatic send(input int n, input logic [8:0] v, input logic stop);
		int i;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (i = 0; i < n; i++) begin
			rxd <= v[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= stop;
		repeat (BIT) @(posedge clk);
		rxd <= 1'b1;
	endtask : send
	// Sample each bit in its middle; returns in the stop bit
	task automatic take(input int n, output logic [8:0] v);
		int i;
		v = 9'h000;
		while (txd !== 1'b0) @(posedge clk);
		repeat (BIT / 2) @(posedge clk);
		for (i = 0; i < n; i++) begin
			repeat (BIT) @(posedge clk);
			v[i] = txd;
		end
		repeat (BIT) @(posedge clk);
	endtask : take
	// Length in clocks of the next low stretch
	task automatic low_len(output int c);
		c = 0;
		while (txd !== 1'b0) @(posedge clk);
		while (txd === 1'b0) begin
			@(posedge clk);
			c++;
		end
	endtask : low_len
endmodule : asf_remote
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the serial port over its register bus and line.
// Assumes divisor 2, so one bit is 32 clocks at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
module testbench import asf_pkg::*;;
	localparam int BIT = 32;
	logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, rxd;
	logic awready, wready, bvalid, arready, rvalid, txd_o, txd_oe_n, irq;
	logic [7:0] awaddr, araddr, b;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [8:0] v;
	int mismatches, checks, seed, n, i;
	// Released pin is pulled up
	wire logic tx_line = txd_oe_n ? 1'b1 : txd_o;
	asf_serial_port DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd_i(rxd), .txd_i(tx_line),
		.txd_o(txd_o), .txd_oe_n(txd_oe_n), .irq(irq));
	asf_remote #(.BIT(BIT)) rem (.clk(clk), .txd(tx_line), .rxd(rxd));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Address and data offered together, each released when taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] val);
		@(posedge clk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, val};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] idx);
		@(posedge clk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic rdchk(input logic [3:0] idx, input logic [31:0] m, input logic [31:0] exp);
		rd(idx);
		chk(d & m, exp);
	endtask : rdchk
	// Only direction and break length are writable
	function automatic logic [31:0] e_st2(input logic [7:0] x);
		return {24'h0, x & 8'h06};
	endfunction : e_st2
	// Break length: 10/11 bits, three more when long
	function automatic logic [31:0] e_brk(input int k);
		return BIT * ((k > 1 ? 11 : 10) + (k % 2 == 1 ? 3 : 0));
	endfunction : e_brk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		wrap_up;
	end
	// Main sequence
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h1;
		seed = 39109;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rdchk(IDX_STATUS_TWO, 32'hff, 32'h0);
		for (i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			wr(IDX_STATUS_TWO, b);
			rdchk(IDX_STATUS_TWO, 32'hff, e_st2(b));
		end
		// Unmapped place answers with an error
		wr(4'h9, 8'h5a);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rdchk(4'h9, 32'hffffffff, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		// Single-wire pin direction, and no effect outside that mode
		wr(IDX_CTRL_ONE, 8'h20);
		wr(IDX_STATUS_TWO, 8'h00);
		repeat (2) @(posedge clk);
		chk({31'h0, txd_oe_n}, 32'h1);
		wr(IDX_STATUS_TWO, 8'h02);
		repeat (2) @(posedge clk);
		chk({31'h0, txd_oe_n}, 32'h0);
		wr(IDX_STATUS_TWO, 8'h00);
		wr(IDX_CTRL_ONE, 8'h00);
		repeat (2) @(posedge clk);
		chk({31'h0, txd_oe_n}, 32'h0);
		// Divisor 2, then eight-bit frames with corner bytes first
		wr(IDX_BAUD_HIGH, 8'h00);
		wr(IDX_BAUD_LOW, 8'h02);
		wr(IDX_CTRL_TWO, 8'h0c);
		for (i = 0; i < 4; i++) begin
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			wr(IDX_DATA_LOW, b);
			rem.take(8, v);
			chk({23'h0, v}, {24'h0, b});
		end
		// Odd parity takes the place of the data msb
		wr(IDX_CTRL_ONE, 8'h03);
		b = 8'($random(seed));
		wr(IDX_DATA_LOW, b);
		rem.take(8, v);
		chk({23'h0, v}, {24'h0, ~(^b[6:0]), b[6:0]});
		// Nine-bit frames; the ninth bit is resent without a rewrite
		wr(IDX_CTRL_ONE, 8'h10);
		wr(IDX_DATA_HIGH, 8'h40);
		for (i = 0; i < 2; i++) begin
			b = 8'($random(seed));
			wr(IDX_DATA_LOW, b);
			rem.take(9, v);
			chk({23'h0, v}, {24'h1, b});
		end
		// Reception with the active flag seen mid-frame
		b = 8'($random(seed));
		fork
			rem.send(9, {1'b1, b}, 1'b1);
			begin
				repeat (5 * BIT) @(posedge clk);
				rdchk(IDX_STATUS_TWO, 32'h07, 32'h01);
			end
		join
		repeat (14 * BIT) @(posedge clk);
		rdchk(IDX_STATUS_TWO, 32'h07, 32'h00);
		rdchk(IDX_STATUS_ONE, 32'h01, 32'h01);
		rdchk(IDX_DATA_HIGH, 32'h80, 32'h80);
		wr(IDX_DATA_HIGH, 8'h00);
		rdchk(IDX_DATA_HIGH, 32'h80, 32'h80);
		rdchk(IDX_DATA_LOW, 32'hff, {24'h0, b});
		// Interrupt raised by unmasking, dropped by clearing
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_STATUS_ONE, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IRQ_MASK, 8'h00);
		// One break per length setting, cleared during its first bit
		for (i = 0; i < 4; i++) begin
			wr(IDX_CTRL_ONE, (i > 1) ? 8'h10 : 8'h00);
			wr(IDX_STATUS_TWO, (i % 2 == 1) ? 8'h04 : 8'h00);
			wr(IDX_CTRL_TWO, 8'h0d);
			fork
				rem.low_len(n);
				begin
					wait (tx_line === 1'b0);
					wr(IDX_CTRL_TWO, 8'h0c);
				end
			join
			chk(n, e_brk(i));
		end
		// Bad stop bit with long break select still set
		rem.send(9, 9'h0ff, 1'b0);
		repeat (2 * BIT) @(posedge clk);
		rdchk(IDX_STATUS_ONE, 32'h08, 32'h08);
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
